// file: core/pmce_pkg.sv
/*
  package of the power monitor calculation engine: input codes, averaging
  codes, widths and fixed scaling constants.
  assumes nothing of its surroundings.
*/
package pmce_pkg;

  // ************************************************************
  // converter inputs
  // ************************************************************
  typedef enum logic [1:0] {
    PMCE_SEL_TEMP  = 2'h0,
    PMCE_SEL_SHUNT = 2'h1,
    PMCE_SEL_RAIL  = 2'h2
  } pmce_sel_t;

  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int unsigned SMP_W     = 16;
  localparam int unsigned ACC_W     = 26;
  localparam int unsigned PWR_W     = 32;
  localparam int unsigned ENE_W     = 48;
  localparam int unsigned AVG_CODE_W = 3;
  // averaging code n selects 2**n samples, n up to 10
  localparam logic [3:0]  AVG_MAX_LOG2 = 4'ha;
  localparam logic [10:0] CNT_RESET    = 11'h000;

  // ************************************************************
  // current full scale and temperature correction
  // ************************************************************
  // full scale of 39.32 a in 1.2 ma steps is 32767 codes
  localparam logic signed [15:0] CUR_FULL_POS = 16'sh7fff;
  localparam logic signed [15:0] CUR_FULL_NEG = -16'sh7fff;
  // correction gain is 1.0 at the reference temperature, q1.15
  localparam logic signed [17:0] TC_UNITY     = 18'sh08000;
  // slope per temperature code, q.15, plain default
  localparam logic signed [17:0] TC_SLOPE     = -18'sh00002;
  // temperature code of 25 deg c at 125 mdeg per step
  localparam logic signed [15:0] TC_REF_CODE  = 16'sh00c8;

endpackage : pmce_pkg

// file: core/pmce_avg_acc.sv
/*
  one averaging accumulator: sums signed samples and divides by a power of
  two when the run ends.
  assumes clear only matters on a cycle that also adds a sample.
*/
`timescale 1ns/1ps
`default_nettype none
module pmce_avg_acc (
  // clock and reset
  input  wire  logic                          sys_clk,
  input  wire  logic                          rst,
  // control
  input  wire  logic                          clear,
  input  wire  logic                          add,
  input  wire  logic [3:0]                    shift,
  // data
  input  wire  logic signed [pmce_pkg::SMP_W-1:0] sample,
  output var   logic signed [pmce_pkg::SMP_W-1:0] mean
);

  logic signed [pmce_pkg::ACC_W-1:0] sum_q;
  logic signed [pmce_pkg::ACC_W-1:0] next_sum;

  // the running sum including the current sample, so the mean needs no
  // extra cycle after the last sample
  assign next_sum = (clear ? '0 : sum_q)
                  + pmce_pkg::ACC_W'(sample);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sum_q <= '0;
    end else if (add) begin
      sum_q <= next_sum;
    end
  end

  always_comb begin
    logic signed [pmce_pkg::ACC_W-1:0] tmp;
    tmp  = next_sum >>> shift;
    mean = tmp[pmce_pkg::SMP_W-1:0];
  end

endmodule // pmce_avg_acc
`default_nettype wire

// file: core/pmce_engine.sv
/*
  measurement and calculation engine: steers the shared converter over
  temperature, shunt and rail, compensates current, averages, and keeps
  power, energy and charge.
  assumes the converter returns one signed sample per request, strobed by
  conv_valid on sys_clk, never before conv_req was given.
*/
//
// Operation
// - one shared converter, inputs selected in turn
// - current and charge come from shunt drop
// - energy from last current and newest rail
// - averaging one gives results straight away
// - each sample adds into its own accumulator
// - after run, averages form power, then outputs
// - energy and charge accumulate every cycle, unaveraged
// - arithmetic runs beside conversions, adds no time
// - temperature correction applied to every current
// - current clipped to converter full scale
// - temperature converted just before each current
// - averaging from one to 1024 samples
// - current, rail, temperature and power outputs hold until complete new result
// - done flag only after whole run
`timescale 1ns/1ps
`default_nettype none
module pmce_engine (
  // clock and reset
  input  wire  logic                          sys_clk,
  input  wire  logic                          rst,
  // control
  input  wire  logic                          run_en,
  input  wire  logic [pmce_pkg::AVG_CODE_W:0] avg_code,
  input  wire  logic                          done_clear,
  // converter
  output var   logic [1:0]                    conv_sel,
  output var   logic                          conv_req,
  input  wire  logic                          conv_valid,
  input  wire  logic signed [pmce_pkg::SMP_W-1:0] conv_data,
  // results
  output var   logic signed [pmce_pkg::SMP_W-1:0] current_q,
  output var   logic signed [pmce_pkg::SMP_W-1:0] rail_q,
  output var   logic signed [pmce_pkg::SMP_W-1:0] temp_q,
  output var   logic signed [pmce_pkg::PWR_W-1:0] power_q,
  output var   logic signed [pmce_pkg::ENE_W-1:0] energy_q,
  output var   logic signed [pmce_pkg::ENE_W-1:0] charge_q,
  output var   logic                          conversion_done_flag
);

  // ************************************************************
  // sequencing
  // ************************************************************
  typedef enum logic [1:0] {
    PMCE_IDLE,
    PMCE_WAIT_TEMP,
    PMCE_WAIT_SHUNT,
    PMCE_WAIT_RAIL
  } pmce_state_t;

  pmce_state_t state_q;
  logic [10:0] cnt_q;
  logic [10:0] cnt_target;
  logic [3:0]  shift;
  logic        first_q;
  logic        last_smp;

  // codes above ten are taken as ten
  assign shift      = (avg_code > pmce_pkg::AVG_MAX_LOG2) ? pmce_pkg::AVG_MAX_LOG2
                                                          : avg_code;
  assign cnt_target = 11'h001 << shift;
  assign last_smp   = (cnt_q + 11'h001) == cnt_target;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q  <= PMCE_IDLE;
      conv_req <= 1'b0;
      conv_sel <= pmce_pkg::PMCE_SEL_TEMP;
    end else begin
      conv_req <= 1'b0;
      unique case (state_q)
        PMCE_IDLE: begin
          if (run_en) begin
            state_q  <= PMCE_WAIT_TEMP;
            conv_req <= 1'b1;
            conv_sel <= pmce_pkg::PMCE_SEL_TEMP;
          end
        end
        PMCE_WAIT_TEMP: begin
          if (conv_valid) begin
            state_q  <= PMCE_WAIT_SHUNT;
            conv_req <= 1'b1;
            conv_sel <= pmce_pkg::PMCE_SEL_SHUNT;
          end
        end
        PMCE_WAIT_SHUNT: begin
          if (conv_valid) begin
            state_q  <= PMCE_WAIT_RAIL;
            conv_req <= 1'b1;
            conv_sel <= pmce_pkg::PMCE_SEL_RAIL;
          end
        end
        PMCE_WAIT_RAIL: begin
          // with run_en high the next cycle starts at once; arithmetic never holds it back
          if (conv_valid) begin
            state_q  <= run_en ? PMCE_WAIT_TEMP : PMCE_IDLE;
            conv_req <= run_en;
            conv_sel <= pmce_pkg::PMCE_SEL_TEMP;
          end
        end
      endcase
    end
  end

  logic rail_done;
  assign rail_done = (state_q == PMCE_WAIT_RAIL) && conv_valid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q   <= pmce_pkg::CNT_RESET;
      first_q <= 1'b1;
    end else if (rail_done) begin
      cnt_q   <= last_smp ? pmce_pkg::CNT_RESET : cnt_q + 11'h001;
      first_q <= last_smp;
    end
  end

  // ************************************************************
  // temperature compensation and clipping of current
  // ************************************************************
  logic signed [pmce_pkg::SMP_W-1:0] temp_smp_q;
  logic signed [pmce_pkg::SMP_W-1:0] cur_smp_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temp_smp_q <= '0;
    end else if (state_q == PMCE_WAIT_TEMP && conv_valid) begin
      temp_smp_q <= conv_data;
    end
  end

  // the gain uses the temperature converted just before this shunt sample
  logic signed [35:0] dt_fix;
  assign dt_fix = 36'(temp_smp_q) - 36'(pmce_pkg::TC_REF_CODE);

  logic signed [35:0] cur_prod2;
  logic signed [pmce_pkg::SMP_W-1:0] cur_corr;
  always_comb begin
    logic signed [35:0] g;
    logic signed [35:0] q;
    g         = 36'(pmce_pkg::TC_UNITY) + dt_fix * 36'(pmce_pkg::TC_SLOPE);
    cur_prod2 = 36'(conv_data) * g;
    q         = cur_prod2 >>> 15;
    if (q > 36'(pmce_pkg::CUR_FULL_POS)) begin
      cur_corr = pmce_pkg::CUR_FULL_POS;
    end else if (q < 36'(pmce_pkg::CUR_FULL_NEG)) begin
      cur_corr = pmce_pkg::CUR_FULL_NEG;
    end else begin
      cur_corr = q[pmce_pkg::SMP_W-1:0];
    end
  end

  // latest compensated current, kept for the power of the next rail sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_smp_q <= '0;
    end else if (state_q == PMCE_WAIT_SHUNT && conv_valid) begin
      cur_smp_q <= cur_corr;
    end
  end

  // ************************************************************
  // averaging
  // ************************************************************
  logic signed [pmce_pkg::SMP_W-1:0] cur_mean;
  logic signed [pmce_pkg::SMP_W-1:0] rail_mean;
  logic signed [pmce_pkg::SMP_W-1:0] temp_mean;

  // with a single sample the mean equals the sample itself
  pmce_avg_acc u_acc_cur (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (first_q),
    .add     (rail_done),
    .shift   (shift),
    .sample  (cur_smp_q),
    .mean    (cur_mean)
  );

  pmce_avg_acc u_acc_rail (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (first_q),
    .add     (rail_done),
    .shift   (shift),
    .sample  (conv_data),
    .mean    (rail_mean)
  );

  pmce_avg_acc u_acc_temp (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (first_q),
    .add     (rail_done),
    .shift   (shift),
    .sample  (temp_smp_q),
    .mean    (temp_mean)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  logic signed [pmce_pkg::PWR_W-1:0] inst_power;
  assign inst_power = pmce_pkg::PWR_W'(cur_smp_q) * pmce_pkg::PWR_W'(conv_data);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      current_q <= '0;
      rail_q    <= '0;
      temp_q    <= '0;
      power_q   <= '0;
    end else if (rail_done && last_smp) begin
      // one edge loads the whole set, so no mixed read is possible
      current_q <= cur_mean;
      rail_q    <= rail_mean;
      temp_q    <= temp_mean;
      power_q   <= pmce_pkg::PWR_W'(cur_mean) * pmce_pkg::PWR_W'(rail_mean);
    end
  end

  // energy and charge on every cycle, independent of averaging
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      energy_q <= '0;
      charge_q <= '0;
    end else if (rail_done) begin
      energy_q <= energy_q + pmce_pkg::ENE_W'(inst_power);
      charge_q <= charge_q + pmce_pkg::ENE_W'(cur_smp_q);
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (rail_done && last_smp) begin
      conversion_done_flag <= 1'b1;
    end else if (done_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

endmodule // pmce_engine
`default_nettype wire

// file: tb/pmce_engine_properties.sv
/*
  port checker of the calculation engine, bound to its top module.
  assumes one clock sys_clk and a synchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module pmce_engine_checker (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // control and converter
  input wire logic               done_clear,
  input wire logic               run_en,
  input wire logic [1:0]         conv_sel,
  input wire logic               conv_req,
  input wire logic               conv_valid,
  // results
  input wire logic signed [15:0] current_q,
  input wire logic signed [15:0] rail_q,
  input wire logic signed [15:0] temp_q,
  input wire logic signed [31:0] power_q,
  input wire logic signed [47:0] energy_q,
  input wire logic signed [47:0] charge_q,
  input wire logic               conversion_done_flag
);
  // ************************************************************
  // rail strobe history
  // ************************************************************
  logic       rail_now;
  logic       rail_seen_q;
  assign rail_now = conv_valid && (conv_sel == 2'h2);
  // results may change only on the very edge that takes a rail sample, never later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rail_seen_q <= 1'b0;
    end else begin
      rail_seen_q <= rail_now;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_req_single_pulse: assert property (conv_req |=> !conv_req)
    else $error("request longer than one cycle");
  a_sel_holds: assert property (!conv_req |-> $stable(conv_sel))
    else $error("input select moved without request");
  a_shunt_after_temp: assert property (conv_req && conv_sel == 2'h1 |-> $past(conv_sel) == 2'h0)
    else $error("shunt not preceded by temperature");
  a_rail_after_shunt: assert property (conv_req && conv_sel == 2'h2 |-> $past(conv_sel) == 2'h1)
    else $error("rail not preceded by shunt");
  a_no_added_time: assert property (conv_valid && conv_sel != 2'h2 |=> conv_req)
    else $error("gap before next request");
  a_temp_after_rail: assert property (rail_now && run_en |=> conv_req && conv_sel == 2'h0)
    else $error("new cycle does not start with temperature");
  a_results_hold: assert property ($changed(current_q) || $changed(rail_q) || $changed(temp_q)
    || $changed(power_q) |-> rail_seen_q)
    else $error("result changed without rail sample");
  a_results_together: assert property ($changed(current_q) || $changed(rail_q)
    || $changed(power_q) |-> conversion_done_flag)
    else $error("result changed outside run end");
  a_accum_each_rail: assert property ($changed(energy_q) || $changed(charge_q) |-> rail_seen_q)
    else $error("accumulator changed without rail sample");
  a_flag_clears: assert property (done_clear && !rail_now |=> !conversion_done_flag)
    else $error("done flag not cleared");
  a_flag_after_rail: assert property ($rose(conversion_done_flag) |-> rail_seen_q)
    else $error("done flag set without rail sample");
  c_run_done: cover property ($rose(conversion_done_flag));
  c_rail_req: cover property (conv_req && conv_sel == 2'h2);
  c_clear: cover property (done_clear && conversion_done_flag);
endmodule // pmce_engine_checker
bind pmce_engine pmce_engine_checker chk (
  .sys_clk, .rst, .done_clear, .run_en, .conv_sel, .conv_req, .conv_valid, .current_q,
  .rail_q, .temp_q, .power_q, .energy_q, .charge_q, .conversion_done_flag
);
`default_nettype wire

// file: tb/pmce_adc_model.sv
/*
  model of the shared converter: answers each request lag+1 cycles after it is taken.
  assumes at most one request outstanding.
*/
`timescale 1ns/1ps
`default_nettype none
module pmce_adc_model (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // request side
  input  wire logic               conv_req,
  input  wire logic [1:0]         conv_sel,
  input  wire logic [3:0]         lag,
  input  wire logic signed [15:0] temp_v,
  input  wire logic signed [15:0] shunt_v,
  input  wire logic signed [15:0] rail_v,
  // answer side
  output var  logic               conv_valid,
  output var  logic signed [15:0] conv_data
);
  logic [3:0] wait_q;
  logic       busy_q;
  // ************************************************************
  // conversion
  // ************************************************************
  // data toggles outside a strobe so a stale sample never passes
  always_ff @(posedge sys_clk) begin
    conv_valid <= 1'b0;
    conv_data  <= ~conv_data;
    if (rst) begin
      busy_q    <= 1'b0;
      conv_data <= 16'h0000;
    end else if (conv_req) begin
      busy_q <= 1'b1;
      wait_q <= lag;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q     <= 1'b0;
      conv_valid <= 1'b1;
      conv_data  <= (conv_sel == 2'h0) ? temp_v : (conv_sel == 2'h1) ? shunt_v : rail_v;
    end
  end
endmodule // pmce_adc_model
`default_nettype wire

// file: tb/test_power_monitor_calc_engine.sv
/*
  self-checking bench of the calculation engine with a converter model.
  assumes the engine of core/ and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_power_monitor_calc_engine;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     run_en = 1'b0;
  logic                     done_clear = 1'b0;
  logic [3:0]               avg_code = 4'h0;
  logic [3:0]               lag = 4'h1;
  logic signed [15:0]       temp_v = 16'sh0000;
  logic signed [15:0]       shunt_v = 16'sh0000;
  logic signed [15:0]       rail_v = 16'sh0000;
  wire logic [1:0]          conv_sel;
  wire logic                conv_req, conv_valid, conversion_done_flag;
  wire logic signed [15:0]  conv_data, current_q, rail_q, temp_q;
  wire logic signed [31:0]  power_q;
  wire logic signed [47:0]  energy_q, charge_q;
  int                       bad_count = 0;
  int                       check_count = 0;
  int                       rails;
  always #5 sys_clk = ~sys_clk;
  pmce_engine uut (.sys_clk, .rst, .run_en, .avg_code, .done_clear, .conv_sel, .conv_req, .conv_valid,
    .conv_data, .current_q, .rail_q, .temp_q, .power_q, .energy_q, .charge_q, .conversion_done_flag);
  pmce_adc_model adc (.sys_clk, .rst, .conv_req, .conv_sel, .lag, .temp_v, .shunt_v, .rail_v,
    .conv_valid, .conv_data);
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic signed [47:0] got, input logic signed [47:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic start(input logic [3:0] code, input logic [3:0] slow);
    @(negedge sys_clk);
    rst = 1'b1;
    run_en = 1'b0;
    avg_code = code;
    lag = slow;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    run_en = 1'b1;
    rails = 0;
  endtask
  // current_q must stay at reset value until the run completes
  task automatic wait_done(input int limit, output logic early);
    int n;
    early = 1'b0;
    for (n = 0; n < limit && conversion_done_flag !== 1'b1; n++) begin
      @(negedge sys_clk);
      if (conv_valid && conv_sel == 2'h2) rails++;
      if (conversion_done_flag !== 1'b1 && current_q !== 16'sh0000) early = 1'b1;
    end
    run_en = 1'b0;
    if (conversion_done_flag !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: run never completed", $time);
      results;
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic run_single(input logic signed [15:0] t, s, r, c);
    logic e;
    temp_v = t;
    shunt_v = s;
    rail_v = r;
    start(4'h0, 4'h1);
    wait_done(200, e);
    check(e, 1'b0);
    check(rails, 1);
    check(current_q, c);
    check(rail_q, r);
    check(temp_q, t);
    check(power_q, c * r);
    check(energy_q, c * r);
    check(charge_q, c);
    done_clear = 1'b1;
    @(negedge sys_clk);
    done_clear = 1'b0;
    check(conversion_done_flag, 1'b0);
    $display("%0t single conversion test ended", $time);
  endtask
  task automatic run_avg(input logic [3:0] code, input int n);
    logic e;
    temp_v = 16'sh00c8;
    shunt_v = 16'sh012c;
    rail_v = 16'sh0007;
    start(code, 4'h3);
    wait_done(40000, e);
    check(e, 1'b0);
    check(rails, n);
    check(current_q, 16'sh012c);
    check(rail_q, 16'sh0007);
    check(power_q, 48'sh834);
    check(energy_q, n * 48'sh834);
    check(charge_q, n * 48'sh12c);
    $display("%0t averaging test ended", $time);
  endtask
  initial begin
    run_single(16'sh00c8, 16'sh0064, 16'sh0032, 16'sh0064);
    // most negative code clips to the symmetric full scale
    run_single(16'sh00c8, 16'sh8000, 16'sh0002, 16'sh8001);
    // this temperature drives the correction gain to zero
    run_single(16'sh40c8, 16'sh03e8, 16'sh0003, 16'sh0000);
    // a cool die lifts the gain above one, so full-scale current clips high
    run_single(16'sh00c7, 16'sh7fff, 16'sh0002, 16'sh7fff);
    run_avg(4'h2, 4);
    run_avg(4'hc, 1024);
    results;
  end
endmodule // test_power_monitor_calc_engine
`default_nettype wire
